/* File: src/hmx_pkg.sv */
// Shared constants, carriers and field helpers for the halfword MAC / move unit
package hmx_pkg;
    // Primary opcodes
    localparam logic [5:0] OPC_MAC = 6'h04;
    localparam logic [5:0] OPC_CRL = 6'h13;
    localparam logic [5:0] OPC_EXT = 6'h1f;
    // Accumulate extended opcodes (9-bit)
    localparam logic [8:0] XO_MAC_HI_UMOD = 9'h00c;
    localparam logic [8:0] XO_MAC_LO_SMOD = 9'h1ac;
    localparam logic [8:0] XO_MAC_LO_SSAT = 9'h1ec;
    localparam logic [8:0] XO_MAC_LO_USAT = 9'h1cc;
    localparam logic [8:0] XO_MAC_LO_UMOD = 9'h18c;
    // Move extended opcodes (10-bit)
    localparam logic [9:0] XO_CRF_MOVE = 10'h000;
    localparam logic [9:0] XO_XER_MOVE = 10'h200;
    localparam logic [9:0] XO_READ_CR = 10'h013;
    localparam logic [9:0] XO_READ_MSR = 10'h053;
    localparam logic [9:0] XO_READ_DCR = 10'h143;
    localparam logic [9:0] XO_READ_SPR = 10'h153;
    // APB register byte offsets
    localparam logic [7:0] ADDR_CR = 8'h00;
    localparam logic [7:0] ADDR_XER = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    // Reset values and the counter step
    localparam logic [31:0] CR_RST = 32'h0000_0000;
    localparam logic [3:0] XER_RST = 4'h0;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Saturation limits
    localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
    localparam logic [31:0] SAT_NEG = 32'h8000_0000;
    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [31:0] target;
    } hmx_req_t;

    typedef struct packed {
        logic we;
        logic [31:0] data;
        logic priv_fault;
        logic illegal;
    } hmx_rsp_t;

    // Instruction fields; bit 0 of the encoding is the MSB of the word
    function automatic logic [5:0] f_opcd(logic [31:0] i);
        return i[31:26];
    endfunction
    function automatic logic [8:0] f_xo9(logic [31:0] i);
        return i[9:1];
    endfunction
    function automatic logic [9:0] f_xo10(logic [31:0] i);
        return i[10:1];
    endfunction
    function automatic logic f_oe(logic [31:0] i);
        return i[10];
    endfunction
    function automatic logic f_rc(logic [31:0] i);
        return i[0];
    endfunction
    function automatic logic [2:0] f_dest_field(logic [31:0] i);
        return i[25:23];
    endfunction
    function automatic logic [2:0] f_src_field(logic [31:0] i);
        return i[20:18];
    endfunction
    // Encoded number field halves swap into the register number
    function automatic logic [9:0] f_swap_num(logic [31:0] i);
        return {i[15:11], i[20:16]};
    endfunction
    function automatic logic f_spr_priv(logic [31:0] i);
        return i[20];
    endfunction
    // Read 4-bit condition field n (field 0 is the top nibble)
    function automatic logic [3:0] f_cr_get(logic [31:0] cr, logic [2:0] n);
        logic [31:0] s;
        s = cr << {n, 2'b00};
        return s[31:28];
    endfunction
    // Replace 4-bit condition field n
    function automatic logic [31:0] f_cr_set(logic [31:0] cr, logic [2:0] n,
                                             logic [3:0] v);
        logic [31:0] m;
        logic [31:0] d;
        m = 32'hf000_0000 >> {n, 2'b00};
        d = {v, 28'h000_0000} >> {n, 2'b00};
        return (cr & ~m) | d;
    endfunction
endpackage

/* File: src/hmx_mac.sv */
// Halfword multiply with 33-bit accumulate, modulo and saturating results
`timescale 1ns/1ps
`default_nettype none
module hmx_mac (
    // Operands
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic [31:0] rt,
    // Variant select
    input wire logic is_signed,
    input wire logic is_sat,
    input wire logic use_high,
    // Result
    output logic [31:0] res,
    output logic ovf
);
    logic [15:0] ah;
    logic [15:0] bh;
    logic [31:0] prod;
    logic [32:0] temp;
    logic sovf;

    // Operand halves and product; sign extension keeps the low 32 bits exact
    always_comb begin
        ah = use_high ? a[31:16] : a[15:0];
        bh = use_high ? b[31:16] : b[15:0];
        if (is_signed) begin
            prod = $signed({{16{ah[15]}}, ah}) * $signed({{16{bh[15]}}, bh});
        end else begin
            prod = {16'h0000, ah} * {16'h0000, bh};
        end
        temp = {1'b0, prod} + {1'b0, rt};
    end

    // Overflow and result select
    always_comb begin
        sovf = (prod[31] == rt[31]) && (rt[31] != temp[31]);
        ovf = is_signed ? sovf : temp[32];
        res = temp[31:0];
        if (is_sat && is_signed && sovf) begin
            res = {rt[31], {31{~rt[31]}}};
        end else if (is_sat && !is_signed) begin
            res = temp[31:0] | {32{temp[32]}};
        end
    end
endmodule
`default_nettype wire

/* File: src/hmx_sel.sv */
// Register-number swap and privilege check for the special reads
`timescale 1ns/1ps
`default_nettype none
module hmx_sel (
    // Instruction and mode
    input wire logic [31:0] instr,
    input wire logic supervisor,
    input wire logic is_dcr,
    input wire logic is_msr,
    input wire logic is_spr,
    // Outputs
    output logic [9:0] num,
    output logic priv_fault
);
    // Halves of the encoded field are swapped before use
    always_comb begin
        num = hmx_pkg::f_swap_num(instr);
        priv_fault = !supervisor && (is_dcr || is_msr
                     || (is_spr && hmx_pkg::f_spr_priv(instr)));
    end
endmodule
`default_nettype wire

/* File: src/hmx_exec.sv */
// Halfword MAC and move execution stage with APB state access
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module hmx_exec (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Instruction issue
    input wire logic IN_VALID,
    input wire hmx_pkg::hmx_req_t IN_REQ,
    input wire logic IN_SUPERVISOR,
    // Completion
    output logic OUT_VALID,
    output hmx_pkg::hmx_rsp_t OUT_RSP,
    // Architected flag state
    output logic [31:0] CR_VALUE,
    output logic [3:0] XER_FLAGS,
    // Special and device-control read ports
    output logic [9:0] SPR_NUM,
    input wire logic [31:0] SPR_RDATA,
    input wire logic SPR_VALID,
    output logic [9:0] DCR_NUM,
    input wire logic [31:0] DCR_RDATA,
    input wire logic DCR_VALID,
    input wire logic [31:0] MSR_VALUE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    logic [31:0] cr_ff, nxt_cr;
    logic [3:0] xer_ff, nxt_xer;
    logic out_valid_ff, nxt_out_valid;
    hmx_pkg::hmx_rsp_t rsp_ff, nxt_rsp;
    logic [15:0] done_cnt_ff, nxt_done_cnt;
    logic [15:0] bad_cnt_ff, nxt_bad_cnt;
    logic [31:0] instr;
    logic is_mac, is_signed, is_sat, use_high;
    logic is_crf, is_xmv, is_rcr, is_msr, is_dcr, is_spr;
    logic [31:0] mac_res;
    logic mac_ovf;
    logic [9:0] sel_num;
    logic priv_fault;
    logic apb_wr, apb_hit;
    logic [31:0] apb_rd;
    logic [3:0] xer_base;
    logic [31:0] cr_base;
    logic so_new;

    assign instr = IN_REQ.instr;

    // Decode of the handled opcode group
    always_comb begin
        is_mac = 1'b0;
        is_signed = 1'b0;
        is_sat = 1'b0;
        use_high = 1'b0;
        if (hmx_pkg::f_opcd(instr) == hmx_pkg::OPC_MAC) begin
            case (hmx_pkg::f_xo9(instr))
                hmx_pkg::XO_MAC_HI_UMOD: begin
                    is_mac = 1'b1;
                    use_high = 1'b1;
                end
                hmx_pkg::XO_MAC_LO_SMOD: begin
                    is_mac = 1'b1;
                    is_signed = 1'b1;
                end
                hmx_pkg::XO_MAC_LO_SSAT: begin
                    is_mac = 1'b1;
                    is_signed = 1'b1;
                    is_sat = 1'b1;
                end
                hmx_pkg::XO_MAC_LO_USAT: begin
                    is_mac = 1'b1;
                    is_sat = 1'b1;
                end
                hmx_pkg::XO_MAC_LO_UMOD: begin
                    is_mac = 1'b1;
                end
                default: begin
                    is_mac = 1'b0;
                end
            endcase
        end
        is_crf = hmx_pkg::f_opcd(instr) == hmx_pkg::OPC_CRL
                 && hmx_pkg::f_xo10(instr) == hmx_pkg::XO_CRF_MOVE;
        is_xmv = hmx_pkg::f_opcd(instr) == hmx_pkg::OPC_EXT
                 && hmx_pkg::f_xo10(instr) == hmx_pkg::XO_XER_MOVE;
        is_rcr = hmx_pkg::f_opcd(instr) == hmx_pkg::OPC_EXT
                 && hmx_pkg::f_xo10(instr) == hmx_pkg::XO_READ_CR;
        is_msr = hmx_pkg::f_opcd(instr) == hmx_pkg::OPC_EXT
                 && hmx_pkg::f_xo10(instr) == hmx_pkg::XO_READ_MSR;
        is_dcr = hmx_pkg::f_opcd(instr) == hmx_pkg::OPC_EXT
                 && hmx_pkg::f_xo10(instr) == hmx_pkg::XO_READ_DCR;
        is_spr = hmx_pkg::f_opcd(instr) == hmx_pkg::OPC_EXT
                 && hmx_pkg::f_xo10(instr) == hmx_pkg::XO_READ_SPR;
    end

    // Arithmetic
    hmx_mac u_mac (
        .a(IN_REQ.src_a),
        .b(IN_REQ.src_b),
        .rt(IN_REQ.target),
        .is_signed(is_signed),
        .is_sat(is_sat),
        .use_high(use_high),
        .res(mac_res),
        .ovf(mac_ovf)
    );

    // Number swap and privilege
    hmx_sel u_sel (
        .instr(instr),
        .supervisor(IN_SUPERVISOR),
        .is_dcr(is_dcr),
        .is_msr(is_msr),
        .is_spr(is_spr),
        .num(sel_num),
        .priv_fault(priv_fault)
    );

    assign SPR_NUM = sel_num;
    assign DCR_NUM = sel_num;

    // APB decode; zero-wait slave, unmapped offsets answer with an error
    always_comb begin
        apb_wr = PSEL && PENABLE && PWRITE;
        apb_hit = 1'b1;
        case (PADDR)
            hmx_pkg::ADDR_CR: apb_rd = cr_ff;
            hmx_pkg::ADDR_XER: apb_rd = {xer_ff, 28'h000_0000};
            hmx_pkg::ADDR_STAT: apb_rd = {bad_cnt_ff, done_cnt_ff};
            default: begin
                apb_rd = 32'h0000_0000;
                apb_hit = 1'b0;
            end
        endcase
    end

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !apb_hit;
    assign PRDATA = (PSEL && apb_hit) ? apb_rd : 32'h0000_0000;

    // Next state: software writes land first, an instruction in the same
    // cycle then overrides the fields it alters
    always_comb begin
        cr_base = cr_ff;
        xer_base = xer_ff;
        if (apb_wr && PADDR == hmx_pkg::ADDR_CR) begin
            cr_base = PWDATA;
        end
        if (apb_wr && PADDR == hmx_pkg::ADDR_XER) begin
            xer_base = PWDATA[31:28];
        end
        nxt_cr = cr_base;
        nxt_xer = xer_base;
        nxt_out_valid = IN_VALID;
        nxt_rsp = '0;
        nxt_done_cnt = done_cnt_ff;
        nxt_bad_cnt = bad_cnt_ff;
        so_new = xer_base[3];
        if (IN_VALID) begin
            nxt_done_cnt = done_cnt_ff + hmx_pkg::CNT_ONE;
            if (is_mac) begin
                nxt_rsp.we = 1'b1;
                nxt_rsp.data = mac_res;
                if (hmx_pkg::f_oe(instr)) begin
                    nxt_xer[2] = mac_ovf;
                    nxt_xer[3] = xer_base[3] | mac_ovf;
                    so_new = xer_base[3] | mac_ovf;
                end
                if (hmx_pkg::f_rc(instr)) begin
                    nxt_cr[31:28] = {mac_res[31],
                                     !mac_res[31] && mac_res != 32'h0000_0000,
                                     mac_res == 32'h0000_0000, so_new};
                end
            end else if (is_crf) begin
                nxt_cr = hmx_pkg::f_cr_set(cr_base, hmx_pkg::f_dest_field(instr),
                    hmx_pkg::f_cr_get(cr_base, hmx_pkg::f_src_field(instr)));
            end else if (is_xmv) begin
                nxt_cr = hmx_pkg::f_cr_set(cr_base, hmx_pkg::f_dest_field(instr),
                    xer_base);
                nxt_xer = hmx_pkg::XER_RST;
            end else if (is_rcr) begin
                nxt_rsp.we = 1'b1;
                nxt_rsp.data = cr_base;
            end else if (priv_fault) begin
                nxt_rsp.priv_fault = 1'b1;
                nxt_bad_cnt = bad_cnt_ff + hmx_pkg::CNT_ONE;
            end else if (is_msr) begin
                nxt_rsp.we = 1'b1;
                nxt_rsp.data = MSR_VALUE;
            end else if (is_dcr && DCR_VALID) begin
                nxt_rsp.we = 1'b1;
                nxt_rsp.data = DCR_RDATA;
            end else if (is_spr && SPR_VALID) begin
                nxt_rsp.we = 1'b1;
                nxt_rsp.data = SPR_RDATA;
            end else begin
                // Unknown opcode or unimplemented number: retire, no write
                nxt_rsp.illegal = 1'b1;
                nxt_bad_cnt = bad_cnt_ff + hmx_pkg::CNT_ONE;
            end
        end
        // Field zero is left as is for bit-31 moves; no forced clobber
    end

    // State registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cr_ff <= hmx_pkg::CR_RST;
            xer_ff <= hmx_pkg::XER_RST;
            out_valid_ff <= 1'b0;
            rsp_ff <= '0;
            done_cnt_ff <= '0;
            bad_cnt_ff <= '0;
        end else begin
            cr_ff <= nxt_cr;
            xer_ff <= nxt_xer;
            out_valid_ff <= nxt_out_valid;
            rsp_ff <= nxt_rsp;
            done_cnt_ff <= nxt_done_cnt;
            bad_cnt_ff <= nxt_bad_cnt;
        end
    end

    assign OUT_VALID = out_valid_ff;
    assign OUT_RSP = rsp_ff;
    assign CR_VALUE = cr_ff;
    assign XER_FLAGS = xer_ff;

    // Reference values for the checks below, built apart from the datapath
    logic [31:0] exp_lo_u, exp_hi_u;
    logic [32:0] exp_sum_lo;
    logic no_apb_wr;
    assign exp_lo_u = IN_REQ.target + {16'h0000, IN_REQ.src_a[15:0]} * {16'h0000,
                      IN_REQ.src_b[15:0]};
    assign exp_hi_u = IN_REQ.target + {16'h0000, IN_REQ.src_a[31:16]} * {16'h0000,
                      IN_REQ.src_b[31:16]};
    assign exp_sum_lo = {1'b0, IN_REQ.target} + {17'h0_0000, IN_REQ.src_a[15:0]} *
                        {17'h0_0000, IN_REQ.src_b[15:0]};
    assign no_apb_wr = !apb_wr;

    property p_lo_umod;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_mac && !is_signed && !is_sat && !use_high
        |=> OUT_VALID && OUT_RSP.we && OUT_RSP.data == $past(exp_lo_u);
    endproperty
    a_lo_umod: assert property (p_lo_umod) else $error("lo umod wrong");

    property p_hi_umod;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_mac && use_high |=> OUT_RSP.data == $past(exp_hi_u);
    endproperty
    a_hi_umod: assert property (p_hi_umod) else $error("hi umod wrong");

    property p_usat;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_mac && is_sat && !is_signed
        |=> OUT_RSP.data == ($past(exp_sum_lo[32]) ? hmx_pkg::ALL_ONES
                                                   : $past(exp_sum_lo[31:0]));
    endproperty
    a_usat: assert property (p_usat) else $error("unsigned sat wrong");

    property p_ssat;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_mac && is_sat && is_signed && mac_ovf
        |=> OUT_RSP.data == ($past(IN_REQ.target[31]) ? hmx_pkg::SAT_NEG
                                                      : hmx_pkg::SAT_POS);
    endproperty
    a_ssat: assert property (p_ssat) else $error("signed sat wrong");

    property p_crf;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_crf && no_apb_wr
        |=> hmx_pkg::f_cr_get(CR_VALUE, $past(hmx_pkg::f_dest_field(instr)))
            == hmx_pkg::f_cr_get($past(CR_VALUE), $past(hmx_pkg::f_src_field(instr)));
    endproperty
    a_crf: assert property (p_crf) else $error("field move wrong");

    property p_xmv;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_xmv |=> XER_FLAGS == hmx_pkg::XER_RST
            && hmx_pkg::f_cr_get(CR_VALUE, $past(hmx_pkg::f_dest_field(instr)))
               == $past(XER_FLAGS) || $past(apb_wr);
    endproperty
    a_xmv: assert property (p_xmv) else $error("flag move wrong");

    property p_rcr;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_rcr && no_apb_wr |=> OUT_RSP.we && OUT_RSP.data == $past(CR_VALUE);
    endproperty
    a_rcr: assert property (p_rcr) else $error("cr read wrong");

    property p_priv;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && !IN_SUPERVISOR && (is_dcr || is_msr)
        |=> OUT_RSP.priv_fault && !OUT_RSP.we;
    endproperty
    a_priv: assert property (p_priv) else $error("privilege not enforced");

    property p_swap;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_dcr |-> DCR_NUM[4:0] == instr[20:16] && DCR_NUM[9:5] == instr[15:11];
    endproperty
    a_swap: assert property (p_swap) else $error("number swap wrong");

    property p_rec;
        @(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_mac && hmx_pkg::f_rc(instr)
        |=> CR_VALUE[29] == (OUT_RSP.data == 32'h0000_0000) && CR_VALUE[31] == OUT_RSP.data[31];
    endproperty
    a_rec: assert property (p_rec) else $error("record flags wrong");

    c_ssat_ovf: cover property (@(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_mac && is_sat && is_signed && mac_ovf);
    c_usat_ovf: cover property (@(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_mac && is_sat && !is_signed && mac_ovf);
    c_xmv: cover property (@(posedge CLK) disable iff (!RST_N) IN_VALID && is_xmv);
    c_spr_fault: cover property (@(posedge CLK) disable iff (!RST_N)
        IN_VALID && is_spr && priv_fault);
endmodule
`default_nettype wire

/* File: dv/hmx_core_model.sv */
// Far-side model: special, device-control and machine-state read sources
`timescale 1ns/1ps
`default_nettype none
module hmx_core_model #(
    parameter logic [31:0] MSR_INIT = 32'h0000_8030
) (
    // Number requests
    input wire logic [9:0] spr_num,
    input wire logic [9:0] dcr_num,
    // Read answers
    output logic [31:0] spr_rdata,
    output logic spr_valid,
    output logic [31:0] dcr_rdata,
    output logic dcr_valid,
    output logic [31:0] msr_value
);
    // Only low numbers exist, so high ones reach the invalid-number path
    assign spr_valid = (spr_num[9:7] == 3'h0);
    assign spr_rdata = {6'h15, spr_num, spr_num, 6'h2a};
    assign dcr_valid = ~dcr_num[9];
    assign dcr_rdata = ~{dcr_num, 22'h0};
    assign msr_value = MSR_INIT;
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the halfword MAC and move stage
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic in_valid = 1'b0;
    hmx_pkg::hmx_req_t in_req = '0;
    logic sup = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic out_valid, pready, pslverr, spr_vl, dcr_vl, er;
    hmx_pkg::hmx_rsp_t out_rsp;
    logic [31:0] cr_v, spr_rd, dcr_rd, msr_v, prdata, rd, cr_m;
    logic [3:0] xer_f, xer_m;
    logic [9:0] spr_num, dcr_num;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int nrun = 0;
    int nbad = 0;
    localparam logic [34:0] FM = {1'b1, 32'h0, 2'b11};

    always #20 clk = ~clk;

    hmx_exec DUT (.CLK(clk), .RST_N(rst_n), .IN_VALID(in_valid), .IN_REQ(in_req),
        .IN_SUPERVISOR(sup), .OUT_VALID(out_valid), .OUT_RSP(out_rsp), .CR_VALUE(cr_v),
        .XER_FLAGS(xer_f), .SPR_NUM(spr_num), .SPR_RDATA(spr_rd), .SPR_VALID(spr_vl),
        .DCR_NUM(dcr_num), .DCR_RDATA(dcr_rd), .DCR_VALID(dcr_vl), .MSR_VALUE(msr_v),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    hmx_core_model u_core (.spr_num(spr_num), .dcr_num(dcr_num), .spr_rdata(spr_rd),
        .spr_valid(spr_vl), .dcr_rdata(dcr_rd), .dcr_valid(dcr_vl), .msr_value(msr_v));

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard well above the roughly 800 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // APB master: request held until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // No local limit: only the hang guard may end this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // One issue; the answer is looked at in the single cycle it stands
    task automatic run(input logic [31:0] i, a, b, t, input logic s, input logic [34:0] e,
                       input logic [34:0] m);
        @(posedge clk);
        in_valid <= 1'b1;
        in_req <= {i, a, b, t};
        sup <= s;
        nrun++;
        if ((e & m & 35'h3) != 35'h0) nbad++;
        @(posedge clk);
        in_valid <= 1'b0;
        #1;
        chk(out_valid, 1'b1);
        chk(out_rsp & m, e & m);
    endtask

    function automatic logic [31:0] mk_mv(input logic [5:0] op, input logic [14:0] f,
                                          input logic [9:0] x, input logic r);
        return {op, f, x, r};
    endfunction

    // Expected accumulate result with its overflow indication on top
    function automatic logic [32:0] mac(input logic [8:0] x, input logic [31:0] a, b, t);
        logic [15:0] ha;
        logic [15:0] hb;
        logic [31:0] p;
        logic [32:0] s;
        logic sg;
        logic ov;
        logic [31:0] r;
        ha = (x == hmx_pkg::XO_MAC_HI_UMOD) ? a[31:16] : a[15:0];
        hb = (x == hmx_pkg::XO_MAC_HI_UMOD) ? b[31:16] : b[15:0];
        sg = (x == hmx_pkg::XO_MAC_LO_SMOD) || (x == hmx_pkg::XO_MAC_LO_SSAT);
        if (sg) p = $signed(ha) * $signed(hb);
        else p = ha * hb;
        s = {1'b0, p} + {1'b0, t};
        ov = sg ? (p[31] == t[31]) && (t[31] != s[31]) : s[32];
        r = s[31:0];
        if (x == hmx_pkg::XO_MAC_LO_SSAT && ov) r = t[31] ? hmx_pkg::SAT_NEG : hmx_pkg::SAT_POS;
        if (x == hmx_pkg::XO_MAC_LO_USAT) r = r | {32{s[32]}};
        return {ov, r};
    endfunction

    logic [8:0] xos [5] = '{hmx_pkg::XO_MAC_HI_UMOD, hmx_pkg::XO_MAC_LO_SMOD,
        hmx_pkg::XO_MAC_LO_SSAT, hmx_pkg::XO_MAC_LO_USAT, hmx_pkg::XO_MAC_LO_UMOD};

    initial begin
        logic [31:0] a, b, t;
        logic [32:0] e;
        logic [9:0] n;
        logic [2:0] d, s;
        logic o, r, ok, pr, sl, sp;
        void'($urandom(49));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, register access and an unmapped offset
        apb(1'b0, hmx_pkg::ADDR_CR, 32'h0);
        chk(rd, hmx_pkg::CR_RST);
        apb(1'b0, hmx_pkg::ADDR_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, hmx_pkg::ADDR_XER, 32'hffff_ffff);
        apb(1'b0, hmx_pkg::ADDR_XER, 32'h0);
        chk(rd, 32'hf000_0000);
        chk(xer_f, 4'hf);
        apb(1'b1, 8'h0c, 32'h1234_5678);
        chk(er, 1'b1);
        apb(1'b0, 8'h0c, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        $display("test apb done");
        // Accumulate forms, random with saturation corners mixed in
        cr_m = $urandom;
        xer_m = 4'h0;
        apb(1'b1, hmx_pkg::ADDR_CR, cr_m);
        apb(1'b1, hmx_pkg::ADDR_XER, 32'h0);
        for (int k = 0; k < 300; k++) begin
            a = $urandom;
            b = $urandom;
            t = $urandom;
            o = 1'($urandom);
            r = 1'($urandom);
            if (k % 7 == 0) {a, b, t} = {32'h8000_8000, 32'h8000_8000, 32'h7fff_f000};
            if (k % 7 == 1) {a, b, t} = {32'h8000_8000, 32'h7fff_7fff, 32'h8000_0000};
            if (k % 7 == 2) t = 32'hffff_ffff;
            e = mac(xos[k % 5], a, b, t);
            run({hmx_pkg::OPC_MAC, 15'h0, o, xos[k % 5], r}, a, b, t, 1'($urandom),
                {1'b1, e[31:0], 2'b00}, '1);
            if (o) xer_m[3:2] = {xer_m[3] | e[32], e[32]};
            if (r) cr_m[31:28] = {e[31], ~e[31] && e[31:0] != 0, e[31:0] == 0, xer_m[3]};
            chk({cr_v, xer_f}, {cr_m, xer_m});
        end
        $display("test mac done");
        // Field moves: every destination, and exception flags into fields
        for (int k = 0; k < 16; k++) begin
            d = k[2:0];
            s = 3'($urandom);
            if (k < 8) begin
                run(mk_mv(hmx_pkg::OPC_CRL, {d, 2'b00, s, 7'h0}, hmx_pkg::XO_CRF_MOVE, 1'b0),
                    a, b, t, 1'b0, '0, '0);
                cr_m[31 - 4 * d -: 4] = cr_m[31 - 4 * s -: 4];
            end else begin
                xer_m = 4'($urandom);
                apb(1'b1, hmx_pkg::ADDR_XER, {xer_m, 28'h0});
                run(mk_mv(hmx_pkg::OPC_EXT, {d, 12'h0}, hmx_pkg::XO_XER_MOVE, 1'b0),
                    a, b, t, 1'b0, '0, '0);
                cr_m[31 - 4 * d -: 4] = xer_m;
                xer_m = 4'h0;
            end
            chk({cr_v, xer_f}, {cr_m, xer_m});
        end
        run(mk_mv(hmx_pkg::OPC_EXT, 15'h0, hmx_pkg::XO_READ_CR, 1'b1), a, b, t, 1'b0,
            {1'b1, cr_m, 2'b00}, '1);
        chk(cr_v, cr_m);
        run(mk_mv(hmx_pkg::OPC_EXT, 15'h0, hmx_pkg::XO_READ_MSR, 1'b0), a, b, t, 1'b1,
            {1'b1, msr_v, 2'b00}, '1);
        run(mk_mv(hmx_pkg::OPC_EXT, 15'h0, hmx_pkg::XO_READ_MSR, 1'b0), a, b, t, 1'b0,
            {1'b0, 32'h0, 2'b10}, FM);
        $display("test moves done");
        // Numbered reads: swap, privilege and unimplemented numbers
        for (int k = 0; k < 40; k++) begin
            sl = k[0];
            n = 10'($urandom);
            if (k[1]) n[9:7] = 3'h0;
            sp = 1'($urandom);
            ok = sl ? ~n[9] : (n[9:7] == 3'h0);
            pr = sl | n[4];
            e = {1'b0, sl ? ~{n, 22'h0} : {6'h15, n, n, 6'h2a}};
            run(mk_mv(hmx_pkg::OPC_EXT, {5'h0, n[4:0], n[9:5]},
                sl ? hmx_pkg::XO_READ_DCR : hmx_pkg::XO_READ_SPR, 1'b0), a, b, t, sp,
                (pr && !sp) ? 35'h2 : (!ok ? 35'h1 : {1'b1, e[31:0], 2'b00}),
                (pr && !sp) || !ok ? FM : '1);
            chk(sl ? dcr_num : spr_num, n);
        end
        run(32'h0000_1234, a, b, t, 1'b1, 35'h1, FM);
        run(mk_mv(hmx_pkg::OPC_EXT, 15'h0, 10'h3ff, 1'b0), a, b, t, 1'b1, 35'h1, FM);
        // Retired and refused counts seen by software after all issues
        apb(1'b0, hmx_pkg::ADDR_STAT, 32'h0);
        chk(rd, {nbad[15:0], nrun[15:0]});
        $display("test numbered reads done");
        give_verdict();
    end
endmodule
`default_nettype wire
